// >>> hdl/wsr_top.sv
`timescale 1ns/1ps
module wsr_top
  import wsr_pkg::*;
#(
  parameter int CYC_MS = wsr_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                           I_SYS_CLK,
  input  wire logic                           I_RST_N,
  // kick sources
  input  wire logic                           I_KICK_INPUT,
  input  wire logic                           I_KICK_INPUT_EN,
  input  wire logic                           I_KICK_CMD,
  // supervision timer configuration
  input  wire logic                           I_WD_EN,
  input  wire logic [wsr_pkg::PERIOD_W-1:0]   I_WD_PERIOD_MS,
  input  wire logic [wsr_pkg::START_SEL_W-1:0] I_WD_START_SEL,
  input  wire logic                           I_TIMEOUT_OUTPUT_EN,
  input  wire logic                           I_TIMEOUT_TO_RST,
  input  wire logic                           I_WD_GPI_TRACK,
  input  wire logic                           I_STICKY_CLR,
  // system reset configuration and conditions
  input  wire logic [wsr_pkg::RAIL_N-1:0]     I_RAIL_PG,
  input  wire logic [wsr_pkg::RAIL_N-1:0]     I_RAIL_SEL,
  input  wire logic [wsr_pkg::GPI_N-1:0]      I_GENERAL_INPUT_PIN,
  input  wire logic [wsr_pkg::GPI_N-1:0]      I_GPI_SEL,
  input  wire logic [wsr_pkg::DLY_SEL_W-1:0]  I_RST_DLY_SEL,
  input  wire logic                           I_RST_PULSE_MODE,
  input  wire logic [wsr_pkg::PULSE_W-1:0]    I_RST_PULSE_MS,
  input  wire logic                           I_RST_CFG_UPDATE,
  // outputs
  output logic                                O_TIMEOUT_OUTPUT,
  output logic                                O_SYS_RST_N,
  output logic                                O_WD_TIMEOUT,
  output logic                                O_WD_TIMEOUT_LATCH,
  output logic                                O_WD_ACTIVE
);
  import wsr_pkg::*;

  localparam int EVAL_W = $clog2(REEVAL_CYC + 1);

  logic            tick;
  logic            kick_s1_r, kick_s2_r, kick_s3_r;
  logic            kick;
  logic            conds_ok;
  logic            wd_expire;
  logic [MS_W-1:0] wd_cnt_r;
  logic [MS_W-1:0] rs_cnt_r;
  logic [MS_W-1:0] dly_ms;
  logic [PERIOD_W-1:0] period_ms;
  logic [PULSE_W-1:0]  pulse_ms;
  logic [EVAL_W-1:0] eval_cnt_r;
  wsr_wd_state_t   wd_state_r, wd_state_nxt;
  wsr_rs_state_t   rs_state_r, rs_state_nxt;

  wsr_ms_tick #(.CYC(CYC_MS)) u_tick (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .o_tick  (tick)
  );

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      kick_s1_r <= 1'b0;
      kick_s2_r <= 1'b0;
      kick_s3_r <= 1'b0;
    end else begin
      kick_s1_r <= I_KICK_INPUT;
      kick_s2_r <= kick_s1_r;
      kick_s3_r <= kick_s2_r;
    end
  end

  // command merged with pin toggle; pin gated by enable
  assign kick = (I_KICK_INPUT_EN && (kick_s2_r != kick_s3_r)) || I_KICK_CMD;

  // clamp period to its programmable range
  assign period_ms = (I_WD_PERIOD_MS < PERIOD_MIN_MS) ? PERIOD_MIN_MS :
                     (I_WD_PERIOD_MS > PERIOD_MAX_MS) ? PERIOD_MAX_MS : I_WD_PERIOD_MS;
  assign pulse_ms  = (I_RST_PULSE_MS < PULSE_MIN_MS) ? PULSE_MIN_MS :
                     (I_RST_PULSE_MS > PULSE_MAX_MS) ? PULSE_MAX_MS : I_RST_PULSE_MS;
  assign dly_ms    = rel_delay_ms((I_RST_DLY_SEL > DLY_SEL_MAX) ? DLY_SEL_MAX : I_RST_DLY_SEL);
  // all selected rails good and selected inputs asserted
  assign conds_ok  = ((I_RAIL_PG | ~I_RAIL_SEL) == '1) && ((I_GENERAL_INPUT_PIN | ~I_GPI_SEL) == '1);

  assign wd_expire = I_WD_EN && (wd_state_r == WSR_WD_RUN) && !kick && (wd_cnt_r >= MS_W'(period_ms));

  always_comb begin
    wd_state_nxt = wd_state_r;
    case (wd_state_r)
      WSR_WD_OFF: begin
        if (I_WD_EN) begin
          wd_state_nxt = (I_WD_START_SEL == '0) ? WSR_WD_RUN : WSR_WD_START;
        end
      end
      WSR_WD_START: begin
        if (wd_cnt_r >= start_wait_ms(I_WD_START_SEL)) begin
          wd_state_nxt = WSR_WD_RUN;
        end
      end
      WSR_WD_RUN: begin
        if (wd_expire) begin
          wd_state_nxt = WSR_WD_EXP;
        end
      end
      WSR_WD_EXP: begin
        if (kick) begin
          wd_state_nxt = WSR_WD_RUN;
        end
      end
      default: wd_state_nxt = WSR_WD_OFF;
    endcase
    if (!I_WD_EN) begin
      wd_state_nxt = WSR_WD_OFF;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      wd_state_r <= WSR_WD_OFF;
    end else begin
      wd_state_r <= wd_state_nxt;
    end
  end

  // kick or state change restarts count; start wait ignores kicks
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      wd_cnt_r <= '0;
    end else if ((kick && (wd_state_r != WSR_WD_START)) || (wd_state_nxt != wd_state_r)) begin
      wd_cnt_r <= '0;
    end else if (tick && (wd_cnt_r != '1)) begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // one-cycle timeout pulse; only when routed to logic output
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_TIMEOUT_OUTPUT <= 1'b0;
    end else begin
      O_TIMEOUT_OUTPUT <= wd_expire && I_TIMEOUT_OUTPUT_EN && !I_TIMEOUT_TO_RST;
    end
  end

  // sticky and live status, set wins over clear
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_WD_TIMEOUT_LATCH <= 1'b0;
      O_WD_TIMEOUT       <= 1'b0;
      O_WD_ACTIVE        <= 1'b0;
    end else begin
      O_WD_TIMEOUT_LATCH <= wd_expire || (O_WD_TIMEOUT_LATCH && !I_STICKY_CLR);
      O_WD_TIMEOUT       <= (wd_state_nxt == WSR_WD_EXP);
      O_WD_ACTIVE        <= (wd_state_nxt == WSR_WD_RUN);
    end
  end

  always_comb begin
    rs_state_nxt = rs_state_r;
    case (rs_state_r)
      WSR_RS_EVAL: begin
        if (eval_cnt_r >= EVAL_W'(REEVAL_CYC - 1)) begin
          rs_state_nxt = WSR_RS_WAIT;
        end
      end
      WSR_RS_WAIT: begin
        if (conds_ok) begin
          rs_state_nxt = WSR_RS_DELAY;
        end
      end
      WSR_RS_DELAY: begin
        if (!conds_ok) begin
          rs_state_nxt = WSR_RS_WAIT;
        end else if (rs_cnt_r >= dly_ms) begin
          rs_state_nxt = I_RST_PULSE_MODE ? WSR_RS_PULSE : WSR_RS_UP;
        end
      end
      WSR_RS_PULSE: begin
        if (rs_cnt_r >= MS_W'(pulse_ms)) begin
          rs_state_nxt = WSR_RS_UP;
        end
      end
      WSR_RS_UP: begin
        if (!conds_ok) begin
          rs_state_nxt = WSR_RS_WAIT;
        end
      end
      WSR_RS_WDHOLD: begin
        // release by delay, or track inputs
        if (rs_cnt_r >= dly_ms) begin
          rs_state_nxt = (I_WD_GPI_TRACK || !conds_ok) ? WSR_RS_WAIT : WSR_RS_UP;
        end
      end
      default: rs_state_nxt = WSR_RS_EVAL;
    endcase
    if (wd_expire && I_TIMEOUT_TO_RST && (rs_state_r != WSR_RS_EVAL)) begin
      rs_state_nxt = WSR_RS_WDHOLD;
    end
    if (I_RST_CFG_UPDATE) begin
      rs_state_nxt = WSR_RS_EVAL;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      rs_state_r <= WSR_RS_EVAL;
    end else begin
      rs_state_r <= rs_state_nxt;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      eval_cnt_r <= '0;
    end else if (rs_state_nxt != WSR_RS_EVAL || I_RST_CFG_UPDATE) begin
      eval_cnt_r <= '0;
    end else begin
      eval_cnt_r <= eval_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      rs_cnt_r <= '0;
    end else if (rs_state_nxt != rs_state_r) begin
      rs_cnt_r <= '0;
    end else if (tick && (rs_cnt_r != '1)) begin
      rs_cnt_r <= rs_cnt_r + 1'b1;
    end
  end

  // asserted out of reset; active low
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_SYS_RST_N <= 1'b0;
    end else begin
      case (rs_state_nxt)
        WSR_RS_UP:    O_SYS_RST_N <= 1'b1;
        WSR_RS_WAIT,
        WSR_RS_DELAY: O_SYS_RST_N <= I_RST_PULSE_MODE;
        default:      O_SYS_RST_N <= 1'b0;
      endcase
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_cfg_req;
    I_RST_CFG_UPDATE;
  endsequence
  sequence s_held_low;
    !O_SYS_RST_N [*2];
  endsequence

  rst_after_por_a: assert property ($rose(I_RST_N) |-> !O_SYS_RST_N)
    else $error("system reset not asserted after power-on reset");
  reconfig_assert_a: assert property (s_cfg_req |=> s_held_low)
    else $error("reconfiguration did not hold reset");
  release_cause_a: assert property ($rose(O_SYS_RST_N) && !I_RST_PULSE_MODE |-> $past(conds_ok))
    else $error("reset released without conditions");
  level_drop_a: assert property (O_SYS_RST_N && !I_RST_PULSE_MODE && !conds_ok && !I_RST_CFG_UPDATE
                                 |=> !O_SYS_RST_N)
    else $error("reset not asserted on condition drop");
  timeout_pulse_a: assert property (O_TIMEOUT_OUTPUT |=> !O_TIMEOUT_OUTPUT)
    else $error("timeout output longer than one cycle");
  timeout_route_a: assert property (O_TIMEOUT_OUTPUT |-> $past(!I_TIMEOUT_TO_RST && I_TIMEOUT_OUTPUT_EN))
    else $error("timeout output while routed to reset");
  kick_restart_a: assert property (kick && wd_state_r == WSR_WD_RUN && I_WD_EN |=> wd_cnt_r == '0)
    else $error("kick did not restart count");
  expire_period_a: assert property (wd_expire |-> wd_cnt_r >= MS_W'(period_ms))
    else $error("timeout before period");
  sticky_hold_a: assert property (O_WD_TIMEOUT_LATCH && !I_STICKY_CLR |=> O_WD_TIMEOUT_LATCH)
    else $error("sticky status lost");
  sticky_set_a: assert property (wd_expire |=> O_WD_TIMEOUT_LATCH && O_WD_TIMEOUT)
    else $error("timeout status not set");
  exp_restart_a: assert property (wd_state_r == WSR_WD_EXP && kick && I_WD_EN |=> O_WD_ACTIVE)
    else $error("no restart after kick");
  merged_hold_a: assert property (wd_expire && I_TIMEOUT_TO_RST && rs_state_r != WSR_RS_EVAL
                                  |=> !O_SYS_RST_N)
    else $error("merged timeout did not assert reset");
endmodule

// >>> pkg/wsr_pkg.sv
package wsr_pkg;
  // clock and timebase
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          MS_PER_S        = 1000;
  localparam int          CYC_PER_MS      = CLK_HZ / MS_PER_S;
  // re-evaluation hold after a reconfiguration, in ns
  localparam int          REEVAL_NS       = 10_000;
  localparam int          CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int          REEVAL_CYC      = REEVAL_NS / CLK_PERIOD_NS;
  // field widths
  localparam int          MS_W            = 21;
  localparam int          PERIOD_W        = 18;
  localparam int          PULSE_W         = 15;
  localparam int          START_SEL_W     = 4;
  localparam int          DLY_SEL_W       = 5;
  localparam int          RAIL_N          = 24;
  localparam int          GPI_N           = 32;
  // programmable ranges in ms
  localparam logic [PERIOD_W-1:0] PERIOD_MIN_MS = 18'h00001;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX_MS = 18'h3f000;
  localparam logic [PULSE_W-1:0]  PULSE_MIN_MS  = 15'h0001;
  localparam logic [PULSE_W-1:0]  PULSE_MAX_MS  = 15'h7e00;
  localparam logic [MS_W-1:0]     START_BASE_MS = 21'h000064;
  localparam logic [DLY_SEL_W-1:0] DLY_SEL_MAX  = 5'h10;

  typedef enum logic [1:0] {WSR_WD_OFF, WSR_WD_START, WSR_WD_RUN, WSR_WD_EXP} wsr_wd_state_t;
  typedef enum logic [2:0] {WSR_RS_EVAL, WSR_RS_WAIT, WSR_RS_DELAY, WSR_RS_PULSE,
                            WSR_RS_UP, WSR_RS_WDHOLD} wsr_rs_state_t;

  // initial wait: 0 = at power up, n = 100 ms * 2^(n-1)
  function automatic logic [MS_W-1:0] start_wait_ms(input logic [START_SEL_W-1:0] sel);
    logic [MS_W-1:0] v;
    v = '0;
    if (sel != '0) begin
      v = START_BASE_MS << (sel - 4'h1);
    end
    return v;
  endfunction

  // release delay code to ms
  function automatic logic [MS_W-1:0] rel_delay_ms(input logic [DLY_SEL_W-1:0] sel);
    logic [MS_W-1:0] v;
    v = '0;
    case (sel)
      5'h00: v = 21'h000000;
      5'h0b: v = 21'h0003fc;
      5'h0c: v = 21'h000802;
      5'h0d: v = 21'h001004;
      5'h0e: v = 21'h001ffe;
      5'h0f: v = 21'h003ffc;
      5'h10: v = 21'h008020;
      default: begin
        if (sel < 5'h0b) begin
          v = 21'h000001 << (sel - 5'h01);
        end else begin
          v = 21'h008020;
        end
      end
    endcase
    return v;
  endfunction
endpackage

// >>> hdl/wsr_ms_tick.sv
`timescale 1ns/1ps
module wsr_ms_tick #(
  parameter int CYC = 50000
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_r;

  // one-cycle tick every millisecond
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end else if (cnt_r == CW'(CYC - 1)) begin
      cnt_r  <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule

// >>> tb/wsr_host.sv
`timescale 1ns/1ps
module wsr_host (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // request from the bench
  input  wire logic i_kick_req,
  // kick pin towards the device
  output logic      o_kick
);
  initial o_kick = 1'b0;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_kick <= 1'b0;
    end else if (i_kick_req) begin
      o_kick <= ~o_kick;
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import wsr_pkg::*;
  localparam int CM = 10;
  logic                   clk, rst_n, kreq, kpin, ken, kcmd, wd_en, to_en, to_rst, sclr, pmode, cfg, trk;
  logic [PERIOD_W-1:0]    period;
  logic [RAIL_N-1:0]      pg, rsel;
  logic [GPI_N-1:0]       general_input_pin, gsel;
  logic [DLY_SEL_W-1:0]   dsel;
  logic [START_SEL_W-1:0] ssel;
  logic [PULSE_W-1:0]     pw;
  logic                   to_out, srst_n, wd_to, wd_lat, wd_act;
  int                     n_mismatch, tests_run, cyc, n, seed, dly, pwi;

  wsr_host wsr_host_inst (.i_clk(clk), .i_rst_n(rst_n), .i_kick_req(kreq), .o_kick(kpin));
  wsr_top #(.CYC_MS(CM)) wsr_top_inst (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_KICK_INPUT(kpin), .I_KICK_INPUT_EN(ken), .I_KICK_CMD(kcmd),
    .I_WD_EN(wd_en), .I_WD_PERIOD_MS(period), .I_WD_START_SEL(ssel), .I_TIMEOUT_OUTPUT_EN(to_en),
    .I_TIMEOUT_TO_RST(to_rst), .I_WD_GPI_TRACK(trk), .I_STICKY_CLR(sclr), .I_RAIL_PG(pg),
    .I_RAIL_SEL(rsel), .I_GENERAL_INPUT_PIN(general_input_pin), .I_GPI_SEL(gsel), .I_RST_DLY_SEL(dsel),
    .I_RST_PULSE_MODE(pmode), .I_RST_PULSE_MS(pw), .I_RST_CFG_UPDATE(cfg),
    .O_TIMEOUT_OUTPUT(to_out), .O_SYS_RST_N(srst_n), .O_WD_TIMEOUT(wd_to),
    .O_WD_TIMEOUT_LATCH(wd_lat), .O_WD_ACTIVE(wd_act));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi, input string msg);
    tests_run++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s took %0d", $time, msg, v);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return srst_n;
      1: return wd_to;
      default: return wd_act;
    endcase
  endfunction

  // cycles until the selected output reaches a value
  task automatic wait_o(input int s, input logic v, output int k);
    k = 0;
    while (pick(s) !== v && k < 5000) begin
      tick(1);
      k++;
    end
  endtask

  task automatic kick(input logic by_pin);
    @(posedge clk);
    if (by_pin) kreq <= 1'b1;
    else kcmd <= 1'b1;
    @(posedge clk);
    kreq <= 1'b0;
    kcmd <= 1'b0;
    #1;
  endtask

  task automatic drive(input int w, input logic v);
    @(posedge clk);
    case (w)
      0: pg[0] <= v;
      1: pg[1] <= v;
      2: general_input_pin[0] <= v;
      3: sclr <= v;
      default: cfg <= v;
    endcase
    #1;
  endtask

  initial begin
    seed = 99;
    {rst_n, kreq, ken, kcmd, wd_en, to_en, to_rst, sclr, pmode, cfg, trk} = '0;
    ssel = 4'h0;
    pw = 15'h0001;
    period = 18'h00003;
    pg = '1;
    general_input_pin = '1;
    rsel = RAIL_N'(($random(seed) & ~32'h00000002) | 32'h00000001);
    gsel = $random(seed) | 32'h00000001;
    dsel = 5'h00;
    repeat (8) @(posedge clk);
    #1;
    chk(srst_n, 1'b0, "reset asserted in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    wait_o(0, 1'b1, n);
    chk_rng(n, REEVAL_CYC - 1, REEVAL_CYC + CM + 5, "first release");
    @(posedge clk);
    {wd_en, to_en, ken} <= 3'b111;
    for (int i = 0; i < 6; i++) begin
      tick(18);
      kick(i[0]);
      chk(wd_to, 1'b0, "no timeout while kicked");
      chk(wd_act, 1'b1, "timer running");
    end
    wait_o(1, 1'b1, n);
    chk_rng(n, 2 * CM - 6, 4 * CM + 5, "expiry time");
    chk(to_out, 1'b1, "timeout pulse");
    chk(wd_lat, 1'b1, "sticky set");
    chk(wd_act, 1'b0, "timer stopped");
    tick(1);
    chk(to_out, 1'b0, "pulse one cycle");
    kick(1'b1);
    tick(4);
    chk(wd_act, 1'b1, "restart by pin");
    chk(wd_lat, 1'b1, "sticky holds");
    drive(3, 1'b1);
    drive(3, 1'b0);
    tick(1);
    chk(wd_lat, 1'b0, "sticky cleared");
    @(posedge clk);
    {to_rst, ken, dsel} <= {2'b10, 5'h02};
    // pin kick while the pin is disabled must not delay the expiry
    kick(1'b1);
    wait_o(1, 1'b1, n);
    chk_rng(n, 0, 2 * CM, "pin ignored when off");
    chk(to_out, 1'b0, "no logic pulse when merged");
    chk(srst_n, 1'b0, "merged timeout resets");
    wait_o(0, 1'b1, n);
    chk_rng(n, CM, 2 * CM + 5, "merged release");
    kick(1'b0);
    @(posedge clk);
    wd_en <= 1'b0;
    dly = 1 + ($unsigned($random(seed)) % 3);
    dsel <= dly[DLY_SEL_W-1:0];
    dly = 1 << (dly - 1);
    drive(1, 1'b0);
    tick(3);
    chk(srst_n, 1'b1, "unselected rail ignored");
    drive(0, 1'b0);
    tick(2);
    chk(srst_n, 1'b0, "rail drop resets");
    drive(0, 1'b1);
    wait_o(0, 1'b1, n);
    chk_rng(n, (dly - 1) * CM, (dly + 1) * CM + 5, "release delay");
    drive(2, 1'b0);
    tick(2);
    chk(srst_n, 1'b0, "input drop resets");
    drive(2, 1'b1);
    wait_o(0, 1'b1, n);
    chk_rng(n, (dly - 1) * CM, (dly + 1) * CM + 5, "release after input");
    drive(4, 1'b1);
    drive(4, 1'b0);
    tick(1);
    chk(srst_n, 1'b0, "reconfig asserts");
    wait_o(0, 1'b1, n);
    chk_rng(n, REEVAL_CYC - 3, REEVAL_CYC + (dly + 1) * CM + 5, "reconfig hold");
    // pulse mode: no level tracking, one low pulse after the delay
    pwi = 1 + ($unsigned($random(seed)) % 3);
    @(posedge clk);
    {pmode, pw} <= {1'b1, pwi[PULSE_W-1:0]};
    drive(0, 1'b0);
    tick(2);
    chk(srst_n, 1'b1, "pulse mode ignores drop");
    drive(0, 1'b1);
    wait_o(0, 1'b0, n);
    chk_rng(n, (dly - 1) * CM, (dly + 1) * CM + 5, "pulse after delay");
    wait_o(0, 1'b1, n);
    chk_rng(n, (pwi - 1) * CM, pwi * CM + 2, "pulse width");
    // initial wait, then merged timeout released through input tracking
    @(posedge clk);
    {pmode, trk, wd_en, ssel, dsel} <= {3'b011, 4'h1, 5'h03};
    wait_o(2, 1'b1, n);
    chk_rng(n, (int'(START_BASE_MS) - 1) * CM, int'(START_BASE_MS) * CM + 5, "start wait");
    wait_o(1, 1'b1, n);
    chk_rng(n, 2 * CM, 3 * CM + 2, "expiry after wait");
    chk(srst_n, 1'b0, "tracked timeout resets");
    wait_o(0, 1'b1, n);
    chk_rng(n, 6 * CM, 8 * CM + 5, "tracked release");
    finish_test();
  end
endmodule
